// *** design/afp_dev.sv ***
// Behaviour
// (RULE_01) Request pin sampled only at select rise
// (RULE_02) Select fall samples input, starts conversion
// (RULE_03) Armed: power down after 16th fall
// (RULE_04) Data keeps shifting while powered down
// (RULE_05) Host may stop clock after 32nd fall
// (RULE_06) Wake on clock rise, plus 0.5 us
// (RULE_07) Host holds select high 0.5 us waking
// (RULE_08) Burst: request high before last frame rise
// (RULE_09) Burst: host stops clock after 16th fall
// (RULE_10) Burst: at most 29 falls per frame
// (RULE_11) Stay down while select stays low
// (RULE_12) Select rise, request low: leave power-down
// (RULE_13) First sample: select high over 1us+acq
// (RULE_14) Below 750 kSPS prefer long frames
// (RULE_15) Long framing if 30th fall seen low
// (RULE_16) Data output undriven while select high
// (RULE_17) After long detect, 16 zeros first
// (RULE_18) Early select rise aborts, next invalid
// (RULE_19) Reset: active, short framing
// Converter end: frame counting, framing mode, power state, data shift.
// Assumes link pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module afp_dev
  import afp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  afp_link_if.dev link,
  input wire logic [afp_pkg::WORD_W-1:0] sample_data,
  output logic sample_take,
  output logic powered_down,
  output logic fully_powered,
  output logic long_frame,
  output logic result_invalid
);
  import afp_pkg::*;

  // Two-stage synchronisers for the three link inputs
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 3'h4; // Idle pin levels, so no false edge
      s2_q <= 3'h4;
      s3_q <= 3'h4;
    end else begin
      s1_q <= {link.cs_n, link.sclk, link.power_down_request_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge decode, all taken from the synchronised copies
  wire cs_n_s = s2_q[2];
  wire cs_rise = s2_q[2] & ~s3_q[2];
  wire cs_fall = ~s2_q[2] & s3_q[2];
  wire sck_rise = s2_q[1] & ~s3_q[1];
  wire sck_fall = ~s2_q[1] & s3_q[1];
  wire req_s = s2_q[0];

  logic [5:0] fall_cnt_q;
  logic seen_rise_q;
  logic armed_q;
  logic long_q;
  logic zeros_q;
  logic invalid_q;
  logic [WORD_W-1:0] result_q;
  logic [WORD_W-1:0] shift_q;
  logic sdo_q;
  logic oe_q;
  logic take_q;
  afp_pwr_e pwr_q;
  logic [WAIT_W-1:0] wake_q;

  wire in_frame = ~cs_n_s;
  wire conv_done = in_frame & sck_fall &
    (fall_cnt_q == CONV_EDGE - 6'h01);
  wire long_hit = in_frame & sck_fall &
    (fall_cnt_q == LONG_DETECT_EDGE - 6'h01);
  wire early_rise = cs_rise & (fall_cnt_q < CONV_EDGE);
  wire shift_now = in_frame & sck_fall & seen_rise_q;

  // Falling-edge count per frame; saturates so overruns do not wrap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fall_cnt_q <= 6'h00;
      seen_rise_q <= 1'b0;
    end else if (cs_fall) begin
      fall_cnt_q <= 6'h00;
      seen_rise_q <= 1'b0;
    end else if (in_frame) begin
      if (sck_fall && fall_cnt_q != 6'h3f)
        fall_cnt_q <= fall_cnt_q + 6'h01;
      if (sck_rise)
        seen_rise_q <= 1'b1;
    end
  end

  // Request pin looked at only on select rising edge [RULE_01] [RULE_08]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      armed_q <= 1'b0;
    else if (cs_rise)
      armed_q <= req_s;
  end

  // Framing mode: long once 30th fall seen, short on a rise before it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      long_q <= 1'b0; // [RULE_19]
      zeros_q <= 1'b0;
    end else if (long_hit) begin
      long_q <= 1'b1; // [RULE_15]
      zeros_q <= 1'b1; // [RULE_17]
    end else if (cs_rise && fall_cnt_q < LONG_DETECT_EDGE) begin
      long_q <= 1'b0; // [RULE_15]
      zeros_q <= 1'b0;
    end
  end

  // Abort marks next frame's data invalid; clears after that frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      invalid_q <= 1'b0;
    else if (early_rise)
      invalid_q <= 1'b1; // [RULE_18]
    else if (cs_rise)
      invalid_q <= 1'b0;
  end

  // Conversion: sample on select fall, result ready at 16th fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= '0;
      take_q <= 1'b0;
    end else begin
      take_q <= cs_fall; // [RULE_02]
      if (conv_done)
        result_q <= sample_data;
    end
  end

  // Shift register: MSB on select fall, next bit per fall after a rise.
  // Short frames show the previous result, or zeros after a long frame;
  // a frame held low past the 16th fall shows the fresh result from there.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= '0;
      sdo_q <= 1'b0;
    end else if (cs_fall) begin
      shift_q <= zeros_q ? '0 : {result_q[WORD_W-2:0], 1'b0}; // [RULE_17]
      sdo_q <= zeros_q ? 1'b0 : result_q[WORD_W-1];
    end else if (conv_done) begin
      shift_q <= {sample_data[WORD_W-2:0], 1'b0};
      sdo_q <= sample_data[WORD_W-1];
    end else if (shift_now) begin
      // Continues regardless of power state [RULE_04]
      shift_q <= {shift_q[WORD_W-2:0], 1'b0};
      sdo_q <= shift_q[WORD_W-1];
    end
  end

  // Output enable follows select only [RULE_16]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      oe_q <= 1'b0;
    else
      oe_q <= in_frame & ~cs_fall ? 1'b1 : cs_fall;
  end

  // Power state: down after conversion when armed, wake by clock/select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_q <= AFP_ACTIVE; // [RULE_19]
      wake_q <= '0;
    end else begin
      unique case (pwr_q)
        AFP_ACTIVE: begin
          if (conv_done && armed_q)
            pwr_q <= AFP_DOWN; // [RULE_03]
        end
        AFP_DOWN: begin
          // Held while select low; rise with request low wakes [RULE_11]
          if (cs_rise && !req_s) begin
            pwr_q <= AFP_WAKING; // [RULE_12]
            wake_q <= WAKE_CYC[WAIT_W-1:0];
          end else if (sck_rise && !in_frame) begin
            pwr_q <= AFP_WAKING; // [RULE_06]
            wake_q <= WAKE_CYC[WAIT_W-1:0];
          end
        end
        AFP_WAKING: begin
          // Fixed settling; host must allow for it [RULE_07]
          if (wake_q == '0)
            pwr_q <= AFP_ACTIVE; // [RULE_06]
          else
            wake_q <= wake_q - 1'b1;
        end
        default: pwr_q <= AFP_ACTIVE;
      endcase
    end
  end

  // Status flags registered so every output is a flip-flop
  logic down_q;
  logic full_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      down_q <= 1'b0;
      full_q <= 1'b1;
    end else begin
      down_q <= (pwr_q == AFP_DOWN);
      full_q <= (pwr_q == AFP_ACTIVE);
    end
  end

  assign link.sdo_o = sdo_q;
  assign link.sdo_oe = oe_q;
  assign sample_take = take_q;
  assign powered_down = down_q;
  assign fully_powered = full_q;
  assign long_frame = long_q;
  assign result_invalid = invalid_q;
endmodule

// *** design/afp_host.sv ***
// Host end: makes select and serial clock, reads data, drives request.
// Assumes data input is asynchronous; the serial clock is divided here.
`timescale 1ns/1ps
module afp_host
  import afp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  afp_link_if.host link,
  input wire logic start,
  input wire logic long_mode,
  input wire logic power_down,
  output logic busy,
  output logic word_valid,
  output logic [afp_pkg::WORD_W-1:0] word_data
);
  import afp_pkg::*;

  afp_host_e st_q;
  logic cs_n_q;
  logic sclk_q;
  logic req_q;
  logic long_q;
  logic was_down_q;
  logic [3:0] half_q;
  logic [5:0] falls_q;
  logic [WAIT_W-1:0] wait_q;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] word_q;
  logic valid_q;
  logic busy_q;
  logic [1:0] sdo_s_q;

  // Data pin synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      sdo_s_q <= 2'h0;
    else
      sdo_s_q <= {sdo_s_q[0], link.sdo};
  end

  // Long frames run 32 falls; short ones stop at 16, never past 29
  wire [5:0] last_fall = long_q ? LONG_FRAME_EDGES : CONV_EDGE; // [RULE_10]
  wire half_done = (half_q == SCLK_HALF - 4'h1);
  wire fall_now = half_done & sclk_q;
  // Select-high time, longer after the frame that follows one sent with the request high [RULE_13] [RULE_07]
  wire [WAIT_W-1:0] high_cyc = was_down_q ?
    FIRST_HIGH_CYC[WAIT_W-1:0] : WAKE_CYC[WAIT_W-1:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= AFP_IDLE;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      req_q <= 1'b0;
      long_q <= 1'b0;
      was_down_q <= 1'b0;
      half_q <= 4'h0;
      falls_q <= 6'h00;
      wait_q <= '0;
      rx_q <= '0;
      word_q <= '0;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      unique case (st_q)
        AFP_IDLE: begin
          req_q <= power_down; // Held before the select rise [RULE_08]
          if (start) begin
            long_q <= long_mode; // Long frames suit slow rates [RULE_14]
            cs_n_q <= 1'b0;
            half_q <= 4'h0;
            falls_q <= 6'h00;
            st_q <= AFP_SHIFT;
            busy_q <= 1'b1;
          end
        end
        AFP_SHIFT: begin
          half_q <= half_done ? 4'h0 : half_q + 4'h1;
          if (half_done)
            sclk_q <= ~sclk_q;
          if (half_done && !sclk_q)
            rx_q <= {rx_q[WORD_W-2:0], sdo_s_q[1]};
          if (fall_now) begin
            falls_q <= falls_q + 6'h01;
            if (falls_q + 6'h01 == last_fall)
              st_q <= AFP_STOP; // Clock stops here [RULE_05] [RULE_09]
          end
        end
        AFP_STOP: begin
          word_q <= rx_q;
          valid_q <= 1'b1;
          cs_n_q <= 1'b1;
          was_down_q <= req_q;
          wait_q <= high_cyc;
          st_q <= AFP_HIGH;
        end
        AFP_HIGH: begin
          if (wait_q == '0) begin
            st_q <= AFP_IDLE;
            busy_q <= 1'b0;
          end else begin
            wait_q <= wait_q - 1'b1;
          end
        end
        default: begin
          st_q <= AFP_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.power_down_request_pin = req_q;
  assign busy = busy_q; // Set on start, cleared on return to idle
  assign word_valid = valid_q;
  assign word_data = word_q;
endmodule

// *** design/afp_link_if.sv ***
// Link between converter end and host end: select, clock, data, request.
// Assumes both ends share the system clock and reset.
`timescale 1ns/1ps
interface afp_link_if;
  logic cs_n;
  logic sclk;
  logic power_down_request_pin;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;
  // Data wire resolves to low when nobody drives it
  assign sdo = sdo_oe ? sdo_o : 1'b0;
  modport dev (
    input cs_n, sclk, power_down_request_pin,
    output sdo_o, sdo_oe
  );
  modport host (
    output cs_n, sclk, power_down_request_pin,
    input sdo
  );
endinterface

// *** design/afp_pkg.sv ***
// Shared constants for the frame power-down control pair.
// Assumes a 200 MHz system clock on both ends.
package afp_pkg;
  // System clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Power-up wait after wake, in nanoseconds
  localparam int unsigned WAKE_TIME_NS = 500;
  localparam int unsigned WAKE_CYC =
    (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // First-sample select-high time past power-down, 1 us plus acquisition
  localparam int unsigned FIRST_HIGH_NS = 1000;
  localparam int unsigned ACQ_TIME_NS = 100;
  localparam int unsigned FIRST_HIGH_CYC =
    ((FIRST_HIGH_NS + ACQ_TIME_NS) * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS + 1;
  // Frame edge counts
  localparam logic [5:0] CONV_EDGE = 6'h10;
  localparam logic [5:0] LONG_DETECT_EDGE = 6'h1e;
  localparam logic [5:0] LONG_FRAME_EDGES = 6'h20;
  localparam logic [5:0] SHORT_MAX_EDGES = 6'h1d;
  // Data width of one result word
  localparam int unsigned WORD_W = 16;
  // Host serial clock half period in system cycles (60 ns period)
  localparam logic [3:0] SCLK_HALF = 4'h6;
  localparam int unsigned WAIT_W = 8;
  typedef enum logic [1:0] {
    AFP_ACTIVE, AFP_DOWN, AFP_WAKING
  } afp_pwr_e;
  typedef enum logic [2:0] {
    AFP_IDLE, AFP_LOW, AFP_SHIFT, AFP_STOP, AFP_HIGH
  } afp_host_e;
endpackage

// *** verification/adc_frame_power_down_control_test.sv ***
// Bench: host end reads frames from the converter end over the link.
// Assumes package, link, both ends and the checker compile first.
`timescale 1ns/1ps
module adc_frame_power_down_control_test;
  import afp_pkg::*;
  logic clk, nrst, start, long_mode, power_down, busy, word_valid;
  logic sample_take, powered_down, fully_powered, long_frame;
  logic result_invalid, pd_seen, fp_low;
  logic [WORD_W-1:0] sample_data, word_data, got, n_take;
  int n_fail, comparisons, cyc;
  afp_link_if link ();
  afp_dev afp_dev_i (.clk(clk), .nrst(nrst), .link(link),
    .sample_data(sample_data), .sample_take(sample_take),
    .powered_down(powered_down), .fully_powered(fully_powered),
    .long_frame(long_frame), .result_invalid(result_invalid));
  afp_host afp_host_i (.clk(clk), .nrst(nrst), .link(link), .start(start),
    .long_mode(long_mode), .power_down(power_down), .busy(busy),
    .word_valid(word_valid), .word_data(word_data));
  afp_link_assertions afp_link_assertions_i (.clk(clk), .nrst(nrst),
    .cs_n(link.cs_n), .sclk(link.sclk),
    .power_down_request_pin(link.power_down_request_pin),
    .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [WORD_W-1:0] v, e);
    comparisons++;
    if (v !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, v, e);
    end
  endtask
  // Power state watch; a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (powered_down === 1'b1) pd_seen <= 1'b1;
    if (fully_powered === 1'b0) fp_low <= 1'b1;
    if (sample_take === 1'b1) n_take <= n_take + 16'h0001;
    if (cyc > 20000) begin
      n_fail++;
      summarize();
    end
  end
  // One host frame; word left unchecked when expectation is unknown
  task automatic frame(input logic lm, pd, input logic [WORD_W-1:0] s, ew,
    input logic ep);
    int i;
    @(negedge clk);
    long_mode = lm;
    power_down = pd;
    sample_data = s;
    pd_seen = 1'b0;
    fp_low = 1'b0;
    n_take = 16'h0000;
    start = 1'b1;
    for (i = 0; i < 50 && busy !== 1'b1; i++) @(negedge clk);
    if (i == 50) n_fail++;
    start = 1'b0;
    for (i = 0; i < 900 && word_valid !== 1'b1; i++) @(negedge clk);
    if (i == 900) n_fail++;
    got = word_data;
    for (i = 0; i < 900 && busy !== 1'b0; i++) @(negedge clk);
    if (i == 900) n_fail++;
    if (!$isunknown(ew)) check(got, ew);
    check(pd_seen, ep);
    check(n_take, 16'h0001);
  endtask
  // Reset, then short and long frames with and without power-down
  initial begin
    nrst = 1'b0;
    start = 1'b0;
    long_mode = 1'b0;
    power_down = 1'b0;
    sample_data = 16'h0;
    pd_seen = 1'b0;
    fp_low = 1'b0;
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    check(powered_down, 1'b0);
    check(fully_powered, 1'b1);
    check(long_frame, 1'b0);
    check(link.sdo_oe, 1'b0);
    frame(1'b0, 1'b0, 16'h1234, 16'hxxxx, 1'b0);
    frame(1'b0, 1'b1, 16'h5678, 16'h1234, 1'b0);
    frame(1'b0, 1'b0, 16'h9abc, 16'h5678, 1'b1);
    check(powered_down, 1'b0);
    check(fully_powered, 1'b1);
    check(fp_low, 1'b1);
    frame(1'b0, 1'b0, 16'hdef0, 16'h9abc, 1'b0);
    frame(1'b1, 1'b0, 16'h1111, 16'h1111, 1'b0);
    check(long_frame, 1'b1);
    frame(1'b1, 1'b1, 16'h2222, 16'h2222, 1'b0);
    frame(1'b1, 1'b0, 16'h3333, 16'h3333, 1'b1);
    frame(1'b0, 1'b0, 16'h4444, 16'h0000, 1'b0);
    check(long_frame, 1'b0);
    frame(1'b0, 1'b0, 16'h5555, 16'h4444, 1'b0);
    check(result_invalid, 1'b0);
    check(link.sdo_oe, 1'b0);
    summarize();
  end
endmodule

// *** verification/afp_link_assertions.sv ***
// Link checker: frame lengths, select gaps, data output timing.
// Assumes one clock for both ends; fed the link signals by name.
`timescale 1ns/1ps
module afp_link_assertions
  import afp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic power_down_request_pin,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  import afp_pkg::*;
  logic cs_q, sclk_q, long_q, seen_q;
  // Request seen at a select rise, and the frame that then powers down
  logic arm_q, dn_q;
  logic [5:0] fcnt_q;
  logic [7:0] hcnt_q;
  // Pin edges seen one cycle late
  wire fall = sclk_q & ~sclk;
  wire cs_fell = cs_q & ~cs_n;
  wire cs_rose = ~cs_q & cs_n;
  wire [5:0] fcnt_now = fcnt_q + {5'h0, fall};
  // Falls per frame; high time saturates, only its floor matters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      fcnt_q <= 6'h0;
      hcnt_q <= 8'h0;
      long_q <= 1'b0;
      seen_q <= 1'b0;
      arm_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      cs_q <= cs_n;
      sclk_q <= sclk;
      fcnt_q <= cs_fell ? 6'h0 : fcnt_now;
      hcnt_q <= !cs_n ? 8'h0 : hcnt_q + {7'h0, hcnt_q != 8'hff};
      if (cs_rose) long_q <= fcnt_now >= LONG_DETECT_EDGE;
      if (cs_fell) seen_q <= 1'b1;
      if (cs_rose) begin
        arm_q <= power_down_request_pin;
        dn_q <= arm_q;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_oe_idle: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("data driven while select high");
  chk_oe_frame: assert property ($fell(cs_n) |-> ##[1:6] sdo_oe)
    else $error("data not driven after select fall");
  chk_bit_hold: assert property (
    $rose(sclk) && !cs_n |=> (!sdo_oe || $stable(sdo_o)) [*4])
    else $error("data moved in clock high phase");
  chk_bit_move: assert property (
    sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sclk)
    else $error("data changed while clock high");
  chk_frame_len: assert property (cs_rose && seen_q |->
    fcnt_now <= SHORT_MAX_EDGES || fcnt_now == LONG_FRAME_EDGES)
    else $error("bad fall count in frame");
  chk_clk_still: assert property (
    cs_n && $past(cs_n) |-> $stable(sclk))
    else $error("clock runs between frames");
  chk_wake_gap: assert property (
    cs_fell && seen_q |-> hcnt_q >= WAKE_CYC)
    else $error("select high time too short");
  chk_long_zeros: assert property (
    long_q && !cs_n && !cs_fell && fcnt_q < CONV_EDGE && sdo_oe |-> !sdo_o)
    else $error("nonzero bit after long frame");
  chk_req_hold: assert property (
    !cs_n && !$past(cs_n) |-> $stable(power_down_request_pin))
    else $error("request moved inside a frame");
  chk_first_gap: assert property (
    cs_fell && dn_q |-> hcnt_q >= FIRST_HIGH_CYC)
    else $error("select high time after power-down too short");
endmodule
